// ==== rtl/cpc_pkg.sv ====
// Package: register map, field layout and constants of the camera port
package cpc_pkg;
    localparam int ADDR_W = 16;
    localparam int IDX_W = 14;
    // Register indexes; byte address is four times the index
    localparam logic [13:0] IDX_CAM1_CLK_DIV = 14'h2000;
    localparam logic [13:0] IDX_CAM1_PORT_CONFIG = 14'h2002;
    localparam logic [13:0] IDX_CAM2_CLOCK_SETTING = 14'h2004;
    localparam logic [13:0] IDX_CAM_ENABLE = 14'h2010;
    localparam logic [13:0] IDX_CAM_STATUS = 14'h2011;
    localparam logic [13:0] IDX_CAM_DATA = 14'h2012;
    // Port config fields
    localparam int CFG_W = 7;
    localparam int CFG_WIDE_BIT = 6;
    localparam int CFG_SRC_BIT = 5;
    localparam int CFG_ORD_LSB = 3;
    localparam int CFG_HPOL_BIT = 2;
    localparam int CFG_VPOL_BIT = 1;
    localparam int CFG_EDGE_BIT = 0;
    localparam logic [6:0] CFG_RESET = 7'h00;
    // Divider fields
    localparam int DIV_W = 5;
    localparam logic [4:0] CAM1_DIV_RESET = 5'h03;
    localparam logic [4:0] CAM2_DIV_RESET = 5'h00;
    localparam logic [4:0] DIV_MIN = 5'h02;
    // Status fields
    localparam int ST_OVF_BIT = 0;
    localparam int ST_NEMPTY_BIT = 1;
    localparam int ST_BUSY_BIT = 2;
    // Component order codes and word slots
    localparam logic [1:0] ORD_UYVY = 2'h0;
    localparam logic [1:0] SLOT_U = 2'h0;
    localparam logic [1:0] SLOT_Y0 = 2'h1;
    localparam logic [1:0] SLOT_V = 2'h2;
    localparam logic [1:0] SLOT_Y1 = 2'h3;
    localparam logic [1:0] PH_WIDE_LAST = 2'h1;
    localparam logic [1:0] PH_NARROW_LAST = 2'h3;
    // Stream and bus
    localparam int PIX_W = 32;
    localparam int FIFO_DEPTH = 16;
    localparam int SYNC_W = 19;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== rtl/cpc_fifo_if.sv ====
// Interface: push and pop sides of the pixel word FIFO
interface cpc_fifo_if #(parameter int WIDTH = 32);
    logic push_valid;
    logic push_ready;
    logic [WIDTH-1:0] push_data;
    logic pop_valid;
    logic pop_ready;
    logic [WIDTH-1:0] pop_data;
    modport fifo(input push_valid, push_data, pop_ready,
                 output push_ready, pop_valid, pop_data);
    modport user(output push_valid, push_data, pop_ready,
                 input push_ready, pop_valid, pop_data);
endinterface

// ==== rtl/cpc_fifo.sv ====
// Pixel word FIFO with registered read data and registered ready
module cpc_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    cpc_fifo_if.fifo f
);
    // DEPTH must be a power of two; pointers wrap naturally
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] mem_cnt_q;
    logic [WIDTH-1:0] out_q;
    logic out_v_q;
    logic ready_q;

    wire push = f.push_valid && ready_q;
    wire pop = out_v_q && f.pop_ready;
    wire load = (mem_cnt_q != '0) && (!out_v_q || pop);
    wire [AW:0] mem_cnt_d = mem_cnt_q + {{AW{1'b0}}, push}
                            - {{AW{1'b0}}, load};
    wire out_v_d = load || (out_v_q && !pop);
    wire [AW:0] total_d = mem_cnt_d + {{AW{1'b0}}, out_v_d};

    assign f.push_ready = ready_q;
    assign f.pop_valid = out_v_q;
    assign f.pop_data = out_q;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_q] <= f.push_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            mem_cnt_q <= '0;
            out_v_q <= 1'b0;
            out_q <= '0;
            ready_q <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (load) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
                out_q <= mem[rd_ptr_q];
            end
            mem_cnt_q <= mem_cnt_d;
            out_v_q <= out_v_d;
            // Registered full keeps the producer path short
            ready_q <= total_d < DEPTH_C;
        end
    end
endmodule

// ==== rtl/cpc_top.sv ====
// Camera port configuration, sampling front end and register slave

// Operation
// - Interface-type bit picks 8-bit or 16-bit YUV 4:2:2 port A bus.
// - Clock-source bit 0 samples data on the camera's own pixel clock.
// - Clock-source bit 1 samples data on the internal divided camera clock.
// - 8-bit order field picks UYVY, VYUY, YUYV or YVYU byte sequence.
// - 16-bit order codes put chroma first lane (00,01) or luma (10,11).
// - Line-reference polarity bit picks high-valid (0) or low-valid (1).
// - Frame-reference polarity bit picks high-valid (0) or low-valid (1).
// - Edge bit latches data on rising (0) or falling (1) pixel clock.
// - Port B output clock divides system clock by five-bit setting plus one.
// - Port B clock setting resets to zero; upper bits unused.
// - Setting n of 2..31 gives n+1 to one; 0 and 1 reserved.
module cpc_top #(
    parameter int FIFO_DEPTH = cpc_pkg::FIFO_DEPTH
) (
    input wire logic MCLK,
    input wire logic ARST_N,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [cpc_pkg::ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    output logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    input wire logic [cpc_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    input wire logic CAM_A_PIXEL_CLK_IN,
    input wire logic CAM_A_LINE_REF,
    input wire logic CAM_A_FRAME_REF,
    input wire logic [7:0] CAM_A_DATA_BUS,
    input wire logic [7:0] CAM_A_DATA_BUS_HI,
    output logic CAM_A_CLK_OUT,
    output logic CAM_B_CLK_OUT
);
    import cpc_pkg::*;

    // ************************************************************
    // Register state and bus decode
    // ************************************************************
    logic [CFG_W-1:0] cfg_q;
    logic [DIV_W-1:0] div_a_q;
    logic [DIV_W-1:0] div_b_q;
    logic en_q;
    logic ovf_q;
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic arready_q;
    logic rvalid_q;
    logic [1:0] bresp_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic [IDX_W-1:0] aw_idx_q;
    logic [7:0] wbyte_q;
    logic wlane_q;
    logic [1:0] phase_q;
    logic push_v_q;
    logic drop;

    cpc_fifo_if #(.WIDTH(PIX_W)) fq ();

    wire [IDX_W-1:0] ar_idx = S_AXI_ARADDR[ADDR_W-1:2];
    wire aw_take = S_AXI_AWVALID && awready_q;
    wire w_take = S_AXI_WVALID && wready_q;
    wire wr_fire = !awready_q && !wready_q && !bvalid_q;
    wire wr_lane = wr_fire && wlane_q;
    wire wr_cfg = wr_lane && (aw_idx_q == IDX_CAM1_PORT_CONFIG);
    wire wr_a = wr_lane && (aw_idx_q == IDX_CAM1_CLK_DIV);
    wire wr_b = wr_lane && (aw_idx_q == IDX_CAM2_CLOCK_SETTING);
    wire wr_en = wr_lane && (aw_idx_q == IDX_CAM_ENABLE);
    wire wr_st = wr_lane && (aw_idx_q == IDX_CAM_STATUS);
    wire aw_hit = aw_idx_q inside {IDX_CAM1_CLK_DIV, IDX_CAM1_PORT_CONFIG,
        IDX_CAM2_CLOCK_SETTING, IDX_CAM_ENABLE, IDX_CAM_STATUS, IDX_CAM_DATA};
    wire ar_take = S_AXI_ARVALID && arready_q;
    wire ar_data = ar_idx == IDX_CAM_DATA;
    wire ar_hit = ar_idx inside {IDX_CAM1_CLK_DIV, IDX_CAM1_PORT_CONFIG,
        IDX_CAM2_CLOCK_SETTING, IDX_CAM_ENABLE, IDX_CAM_STATUS, IDX_CAM_DATA};
    wire rd_b = ar_take && (ar_idx == IDX_CAM2_CLOCK_SETTING);
    wire [31:0] st_word = {29'h0, push_v_q, fq.pop_valid, ovf_q};
    wire [31:0] rd_mux =
        (ar_idx == IDX_CAM1_PORT_CONFIG) ? {25'h0, cfg_q} :
        (ar_idx == IDX_CAM1_CLK_DIV) ? {27'h0, div_a_q} :
        (ar_idx == IDX_CAM2_CLOCK_SETTING) ? {27'h0, div_b_q} :
        (ar_idx == IDX_CAM_ENABLE) ? {31'h0, en_q} :
        (ar_idx == IDX_CAM_STATUS) ? st_word :
        (ar_data && fq.pop_valid) ? fq.pop_data : 32'h0;

    // Reading the data register pops one word; empty reads give zero
    assign fq.pop_ready = ar_take && ar_data && fq.pop_valid;

    assign S_AXI_AWREADY = awready_q;
    assign S_AXI_WREADY = wready_q;
    assign S_AXI_BVALID = bvalid_q;
    assign S_AXI_BRESP = bresp_q;
    assign S_AXI_ARREADY = arready_q;
    assign S_AXI_RVALID = rvalid_q;
    assign S_AXI_RDATA = rdata_q;
    assign S_AXI_RRESP = rresp_q;

    // ************************************************************
    // Write channel
    // ************************************************************
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            aw_idx_q <= '0;
            wbyte_q <= 8'h00;
            wlane_q <= 1'b0;
        end else begin
            if (aw_take) begin
                awready_q <= 1'b0;
                aw_idx_q <= S_AXI_AWADDR[ADDR_W-1:2];
            end else if (wr_fire) begin
                awready_q <= 1'b1;
            end
            if (w_take) begin
                wready_q <= 1'b0;
                wbyte_q <= S_AXI_WDATA[7:0];
                wlane_q <= S_AXI_WSTRB[0];
            end else if (wr_fire) begin
                wready_q <= 1'b1;
            end
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q <= aw_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (S_AXI_BREADY) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Read channel
    // ************************************************************
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= RESP_OKAY;
        end else if (ar_take) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= ar_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_q && S_AXI_RREADY) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
        end
    end

    // ************************************************************
    // Control registers
    // ************************************************************
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cfg_q <= CFG_RESET;
            div_a_q <= CAM1_DIV_RESET;
            div_b_q <= CAM2_DIV_RESET;
            en_q <= 1'b0;
            ovf_q <= 1'b0;
        end else begin
            if (wr_cfg) begin
                cfg_q <= wbyte_q[CFG_W-1:0];
            end
            if (wr_a) begin
                div_a_q <= wbyte_q[DIV_W-1:0];
            end
            if (wr_b) begin
                div_b_q <= wbyte_q[DIV_W-1:0];
            end
            if (wr_en) begin
                en_q <= wbyte_q[0];
            end
            // Set beats a same-cycle write-one clear
            ovf_q <= drop || (ovf_q && !(wr_st && wbyte_q[ST_OVF_BIT]));
        end
    end

    // ************************************************************
    // Camera clock dividers
    // ************************************************************
    logic [DIV_W-1:0] div_n [2];
    wire logic [1:0] clk_o;
    wire logic [1:0] rise_tk;
    wire logic [1:0] fall_tk;
    assign div_n[0] = div_a_q;
    assign div_n[1] = div_b_q;
    assign CAM_A_CLK_OUT = clk_o[0];
    assign CAM_B_CLK_OUT = clk_o[1];

    for (genvar gi = 0; gi < 2; gi++) begin : g_div
        logic [DIV_W-1:0] cnt_q;
        logic clk_q;
        // Reserved settings 0 and 1 park the clock low
        wire run = div_n[gi] >= DIV_MIN;
        wire [DIV_W:0] sum = {1'b0, div_n[gi]} + {{DIV_W{1'b0}}, 1'b1};
        wire [DIV_W-1:0] half = sum[DIV_W:1];
        wire [DIV_W-1:0] cnt_d = (!run || cnt_q >= div_n[gi]) ? '0 :
                                 cnt_q + 1'b1;
        assign clk_o[gi] = clk_q;
        assign rise_tk[gi] = run && (cnt_q == '0) && clk_q;
        assign fall_tk[gi] = run && (cnt_q == half) && !clk_q;
        always_ff @(posedge MCLK or negedge ARST_N) begin
            if (!ARST_N) begin
                cnt_q <= '0;
                clk_q <= 1'b0;
            end else begin
                cnt_q <= cnt_d;
                clk_q <= run && (cnt_d < half);
            end
        end
    end

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [SYNC_W-1:0] syn1_q;
    logic [SYNC_W-1:0] syn2_q;
    logic pclk_old_q;
    wire [SYNC_W-1:0] pins = {CAM_A_PIXEL_CLK_IN, CAM_A_LINE_REF,
        CAM_A_FRAME_REF, CAM_A_DATA_BUS_HI, CAM_A_DATA_BUS};
    wire pclk_s = syn2_q[18];
    wire href_s = syn2_q[17];
    wire vref_s = syn2_q[16];
    wire [7:0] data_hi = syn2_q[15:8];
    wire [7:0] data_lo = syn2_q[7:0];

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            syn1_q <= '0;
            syn2_q <= '0;
            pclk_old_q <= 1'b0;
        end else begin
            syn1_q <= pins;
            syn2_q <= syn1_q;
            pclk_old_q <= pclk_s;
        end
    end

    // ************************************************************
    // Sampling and pixel pair assembly
    // ************************************************************
    function automatic logic [1:0] slot_of(input logic luma,
                                           input logic second,
                                           input logic vsel);
        if (luma) begin
            return second ? SLOT_Y1 : SLOT_Y0;
        end
        return vsel ? SLOT_V : SLOT_U;
    endfunction

    wire wide = cfg_q[CFG_WIDE_BIT];
    wire src_int = cfg_q[CFG_SRC_BIT];
    wire fall_sel = cfg_q[CFG_EDGE_BIT];
    wire [1:0] ord = cfg_q[CFG_ORD_LSB +: 2];
    wire line_ok = href_s ^ cfg_q[CFG_HPOL_BIT];
    wire frame_ok = vref_s ^ cfg_q[CFG_VPOL_BIT];
    // Pixel clock must stay below half of MCLK to be seen
    wire ev_ext = fall_sel ? (pclk_old_q && !pclk_s) :
                             (!pclk_old_q && pclk_s);
    wire ev_int = fall_sel ? fall_tk[0] : rise_tk[0];
    wire ev = src_int ? ev_int : ev_ext;
    wire win = en_q && line_ok && frame_ok;
    wire take = win && ev && !push_v_q;
    assign drop = win && ev && push_v_q;
    wire last = wide ? (phase_q == PH_WIDE_LAST) :
                       (phase_q == PH_NARROW_LAST);
    wire [1:0] slot_lo = wide ?
        slot_of(ord[1], phase_q[0], phase_q[0] ^ ord[0]) :
        slot_of(phase_q[0] ^ ord[1], phase_q[1],
                phase_q[1] ^ ord[0]);
    wire [1:0] slot_hi = slot_of(!ord[1], phase_q[0],
                                 phase_q[0] ^ ord[0]);
    wire logic [PIX_W-1:0] word;

    for (genvar gb = 0; gb < 4; gb++) begin : g_byte
        logic [7:0] byte_q;
        wire hit_lo = take && (slot_lo == 2'(gb));
        wire hit_hi = take && wide && (slot_hi == 2'(gb));
        assign word[gb*8 +: 8] = byte_q;
        always_ff @(posedge MCLK or negedge ARST_N) begin
            if (!ARST_N) begin
                byte_q <= 8'h00;
            end else if (hit_lo) begin
                byte_q <= data_lo;
            end else if (hit_hi) begin
                byte_q <= data_hi;
            end
        end
    end

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            phase_q <= 2'h0;
            push_v_q <= 1'b0;
        end else begin
            if (!win) begin
                phase_q <= 2'h0;
            end else if (take) begin
                phase_q <= last ? 2'h0 : phase_q + 2'h1;
            end
            if (take && last) begin
                push_v_q <= 1'b1;
            end else if (fq.push_ready) begin
                push_v_q <= 1'b0;
            end
        end
    end

    // A full FIFO stalls assembly; bytes seen meanwhile are dropped and set the overflow flag
    assign fq.push_valid = push_v_q;
    assign fq.push_data = word;

    cpc_fifo #(.WIDTH(PIX_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(MCLK),
        .rst_n(ARST_N),
        .f(fq.fifo)
    );

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!ARST_N);

    sequence s_line_drop;
        en_q && ev && !line_ok;
    endsequence

    a_wide_pair_len: assert property (
        $rose(push_v_q) && wide |-> $past(phase_q) == 2'h1)
        else $error("16-bit pair not closed at second sample");
    a_narrow_order: assert property (
        take && !wide && ord == ORD_UYVY && phase_q == 2'h0 |=>
        word[7:0] == $past(data_lo) && $rose(push_v_q) == 1'b0)
        else $error("First byte of UYVY not placed as U");
    a_wide_lanes: assert property (
        take && wide && ord[1] && phase_q == 2'h0 |=>
        word[15:8] == $past(data_lo) &&
        word[(ord[0] ? 16 : 0) +: 8] == $past(data_hi))
        else $error("Luma-first lanes swapped");
    a_line_gate: assert property (
        s_line_drop |=> phase_q == 2'h0 && !$rose(push_v_q))
        else $error("Sample taken outside valid line");
    a_frame_gate: assert property (
        en_q && !frame_ok |=> phase_q == 2'h0)
        else $error("Order not restarted outside valid frame");
    a_ext_edge: assert property (
        take && !src_int |-> (fall_sel ? $fell(pclk_s) : $rose(pclk_s)))
        else $error("External sample on wrong pixel clock edge");
    a_int_edge: assert property (
        take && src_int |-> clk_o[0] == !fall_sel && $changed(clk_o[0]))
        else $error("Internal sample off the output clock edge");
    a_div_wrap: assert property (
        g_div[1].cnt_q == div_b_q && div_b_q >= DIV_MIN && !wr_b |=>
        g_div[1].cnt_q == '0 && clk_o[1])
        else $error("Port B period not n+1 cycles");
    a_div_parked: assert property (
        div_b_q < DIV_MIN && $stable(div_b_q) |=> !clk_o[1])
        else $error("Port B clock runs on reserved setting");
    a_b_read_back: assert property (
        $rose(rvalid_q) && $past(rd_b) |->
        rdata_q[31:DIV_W] == '0 && rdata_q[DIV_W-1:0] == div_b_q)
        else $error("Port B setting reads back wrong");
    a_b_write: assert property (
        wr_b |=> div_b_q == DIV_W'($past(wbyte_q)))
        else $error("Port B divide value not stored");
endmodule

// ==== sim/cpc_cam_model.sv ====
// Camera sensor model: pixel clock, sync references and data lanes
module cpc_cam_model (
    input wire logic clk_out,
    output logic pclk,
    output logic lref,
    output logic fref,
    output logic [7:0] dlo,
    output logic [7:0] dhi
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        pclk = 1'b0;
        lref = 1'b0;
        fref = 1'b0;
        dlo = 8'h00;
        dhi = 8'h00;
    end
    // ****************
    // Line transfer
    // ****************
    // m = {internal clock, line pol, frame pol, edge}
    // Idle levels that close the window before the port is enabled
    task automatic park(input logic [3:0] m);
        #10;
        pclk = m[0];
        lref = m[2];
        fref = m[1];
    endtask
    task automatic send(input logic [3:0] m, input logic [7:0] ql[$],
                        input logic [7:0] qh[$]);
        #10;
        pclk = m[0];
        fref = ~m[1];
        // Internal clock runs free: line opens only with the first byte
        if (!m[3]) begin
            lref = ~m[2];
        end
        #200;
        foreach (ql[i]) begin
            if (m[3]) begin
                @(clk_out iff clk_out === m[0]);
                lref = ~m[2];
            end
            dlo = ql[i];
            dhi = qh[i];
            if (m[3]) begin
                @(clk_out);
            end else begin
                #160 pclk = ~m[0];
                #160 pclk = m[0];
            end
        end
        #180;
        lref = m[2];
        fref = m[1];
        // Released lanes never keep the last byte
        dlo = ~dlo;
        dhi = ~dhi;
        #200;
    endtask
endmodule

// ==== sim/testbench.sv ====
// Self-checking bench for the camera port front end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import cpc_pkg::*;
    // ****************
    // Signals and instances
    // ****************
    localparam logic [15:0] A_DIV = {IDX_CAM1_CLK_DIV, 2'b00};
    localparam logic [15:0] A_CFG = {IDX_CAM1_PORT_CONFIG, 2'b00};
    localparam logic [15:0] A_B = {IDX_CAM2_CLOCK_SETTING, 2'b00};
    localparam logic [15:0] A_EN = {IDX_CAM_ENABLE, 2'b00};
    localparam logic [15:0] A_ST = {IDX_CAM_STATUS, 2'b00};
    localparam logic [15:0] A_DAT = {IDX_CAM_DATA, 2'b00};
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, sel = 1'b0, hi = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [1:0] bresp, rresp;
    logic pclk, lref, fref, clk_a, clk_b;
    logic [7:0] dlo, dhi;
    logic [31:0] exp_q[$];
    int n_fail = 0;
    int n_compared = 0;
    wire logic ck = sel ? clk_a : clk_b;
    always #20 mclk = ~mclk;
    cpc_top #(.FIFO_DEPTH(16)) u_dut (
        .MCLK(mclk), .ARST_N(arst_n),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_AWADDR(awaddr), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_ARADDR(araddr), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .CAM_A_PIXEL_CLK_IN(pclk), .CAM_A_LINE_REF(lref),
        .CAM_A_FRAME_REF(fref), .CAM_A_DATA_BUS(dlo),
        .CAM_A_DATA_BUS_HI(dhi), .CAM_A_CLK_OUT(clk_a),
        .CAM_B_CLK_OUT(clk_b)
    );
    cpc_cam_model u_cam (.clk_out(clk_a), .pclk(pclk), .lref(lref),
        .fref(fref), .dlo(dlo), .dhi(dhi));
    // ****************
    // Bus tasks and compares
    // ****************
    task automatic chk(input string what, input logic [31:0] e,
                       input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic chk_resp(input string what, input logic [1:0] e,
                            input logic [1:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk_resp("write response", er, bresp);
        @(posedge mclk);
    endtask
    task automatic rd(input string what, input logic [15:0] a,
                      input logic [31:0] e, input logic [1:0] er);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(what, e, rdata);
        chk_resp("read response", er, rresp);
        @(posedge mclk);
    endtask
    task automatic period(input logic which, input int n);
        time t0;
        sel = which;
        @(posedge mclk);
        repeat (2) @(posedge ck);
        t0 = $time;
        @(posedge ck);
        chk("clock period", 32'((n + 1) * 40), 32'($time - t0));
        @(posedge mclk);
    endtask
    task automatic capture(input logic [6:0] cfg, input int nw);
        logic [7:0] ql[$], qh[$], b[4];
        logic [3:0] m;
        m = {cfg[5], cfg[2:0]};
        wr(A_EN, 32'h0000_0000, RESP_OKAY);
        wr(A_CFG, {25'h0, cfg}, RESP_OKAY);
        u_cam.park(m);
        wr(A_EN, 32'h0000_0001, RESP_OKAY);
        // Partial line must not leak into the next word
        ql = {8'h5a};
        if (!cfg[6]) ql = {ql, 8'ha5, 8'h3c};
        u_cam.send(m, ql, ql);
        ql = {};
        repeat (nw) begin
            foreach (b[i]) b[i] = 8'($urandom);
            if (exp_q.size() < 17)
                exp_q.push_back({b[3], cfg[3] ? b[0] : b[1], b[2],
                                 cfg[3] ? b[1] : b[0]});
            if (cfg[6]) begin
                ql = {ql, cfg[4] ? b[2] : b[0], cfg[4] ? b[3] : b[1]};
                qh = {qh, cfg[4] ? b[0] : b[2], cfg[4] ? b[1] : b[3]};
            end else if (cfg[4]) begin
                ql = {ql, b[2], b[0], b[3], b[1]};
            end else begin
                ql = {ql, b[0], b[2], b[1], b[3]};
            end
        end
        if (!cfg[6]) qh = ql;
        u_cam.send(m, ql, qh);
        while (exp_q.size() > 0)
            rd("pixel word", A_DAT, exp_q.pop_front(), RESP_OKAY);
        rd("empty data", A_DAT, 32'h0000_0000, RESP_OKAY);
        rd("status", A_ST, {31'h0, nw > 17}, RESP_OKAY);
        wr(A_ST, 32'h0000_0001, RESP_OKAY);
    endtask
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ****************
    // Tests
    // ****************
    initial begin
        #500us;
        n_fail++;
        $display("Error watchdog expected finish seen timeout");
        end_of_test();
    end
    initial begin
        void'($urandom(52));
        repeat (5) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        rd("config reset", A_CFG, 32'h0000_0000, RESP_OKAY);
        rd("port B reset", A_B, 32'h0000_0000, RESP_OKAY);
        rd("divider reset", A_DIV, 32'h0000_0003, RESP_OKAY);
        rd("unmapped", 16'h8004, 32'h0000_0000, RESP_SLVERR);
        wr(16'h8004, 32'h0000_0001, RESP_SLVERR);
        $display("register test done");
        foreach (exp_q[i]) exp_q.delete();
        for (int n = 2; n < 32; n += 29) begin
            wr(A_B, 32'hffff_ffe0 | n, RESP_OKAY);
            rd("port B setting", A_B, 32'(n), RESP_OKAY);
            period(1'b0, n);
        end
        wr(A_B, 32'h0000_0001, RESP_OKAY);
        repeat (40) @(posedge mclk) hi = hi | clk_b;
        chk("parked clock", 32'h0000_0000, {31'h0, hi});
        // Internal sampling needs a ratio above two to one
        wr(A_DIV, 32'h0000_0007, RESP_OKAY);
        period(1'b1, 7);
        $display("clock test done");
        for (int k = 0; k < 8; k++) begin
            capture({k[2], k[0] ^ k[2], k[1:0], 3'(k * 3)}, 2);
            $display("capture case %0d done", k);
        end
        // Eighteen words: sixteen stored, one held, one dropped
        capture(7'h00, 18);
        $display("buffer test done");
        end_of_test();
    end
endmodule
